/* File: inc/pcg_pkg.sv */
// Package for the peripheral clock gate and prescale unit
// Assumes a single system clock domain and a plain register port
package pcg_pkg;
   // Register offsets (word index on the plain port)
   localparam logic [3:0] OFF_GATE3   = 4'h0;
   localparam logic [3:0] OFF_FASTPS  = 4'h1;
   localparam logic [3:0] OFF_SLOWPS  = 4'h2;
   localparam logic [3:0] OFF_PROT    = 4'h3;
   localparam logic [3:0] OFF_PLLRAT  = 4'h4;
   localparam logic [3:0] OFF_STATUS  = 4'h5;
   // Gate register fields
   localparam int         BIT_TMR0    = 8;
   localparam int         NGATE       = 6;
   localparam logic [5:0] GATE_RST    = 6'h27;
   localparam logic [15:0] GATE_MASK  = 16'h3f00;
   // Prescaler and PLL ratio fields
   localparam logic [2:0] FAST_RST    = 3'h1;
   localparam logic [2:0] SLOW_RST    = 3'h2;
   localparam logic [3:0] PLL_RST     = 4'h0;
   localparam logic [15:0] PS_MASK    = 16'h0007;
   localparam logic [15:0] PLL_MASK   = 16'h000f;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } pcg_req_t;

   typedef struct packed {
      logic pin_input_clock_on;
      logic ext_memory_if_clock_on;
      logic dma_clock_on;
      logic timer_two_clock_on;
      logic timer_one_clock_on;
      logic timer_zero_clock_on;
   } pcg_gates_t;
endpackage

/* File: hdl/pcg_top.sv */
// Peripheral clock gating and prescaling unit
// Assumes mclk is the system clock and the register port is synchronous to it
// What this block does
// - Bit 13 gates pin input logic clock
// - Bit 12 gates external memory interface clock
// - Bit 11 gates DMA clock
// - Bit 10 gates timer two clock
// - Bit 9 gates timer one clock
// - Bit 8 gates timer zero clock
// - Fast prescaler N divides by 2N
// - Fast prescaler resets to one
// - Slow prescaler N divides by 2N
// - Slow prescaler resets to two
// - Prescalers writable only with protected access
// - Four-bit PLL ratio control register
`timescale 1ns/10ps
`default_nettype none
module pcg_top (
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              nrst,
   // Register port
   input  wire pcg_pkg::pcg_req_t req,
   output logic [15:0]            rdata,
   // Clock enables, divided clocks and PLL ratio towards peripherals
   output pcg_pkg::pcg_gates_t    gates,
   output logic                   fast_periph_clock,
   output logic                   slow_periph_clock,
   output logic [3:0]             pll_ratio
);
   logic [5:0]  gate_q, gate_d;
   logic [2:0]  fast_q, fast_d, slow_q, slow_d;
   logic        prot_q, prot_d;
   logic [3:0]  pll_q, pll_d;
   logic [15:0] rdata_q, rdata_d;
   logic [5:0]  gout_q, gout_d;
   logic [2:0]  fact_q, fact_d, sact_q, sact_d;
   logic [3:0]  fcnt_q, fcnt_d, scnt_q, scnt_d;
   logic        fclk_q, fclk_d, sclk_q, sclk_d;

   localparam int BITHI = pcg_pkg::BIT_TMR0 + pcg_pkg::NGATE - 1;

   // Register file next state
   always_comb begin
      gate_d  = gate_q;
      fast_d  = fast_q;
      slow_d  = slow_q;
      prot_d  = prot_q;
      pll_d   = pll_q;
      rdata_d = 16'h0000;
      if (req.wr) begin
         case (req.addr)
            pcg_pkg::OFF_GATE3:  gate_d = req.wdata[BITHI:pcg_pkg::BIT_TMR0];
            pcg_pkg::OFF_FASTPS: if (prot_q) fast_d = req.wdata[2:0];
            pcg_pkg::OFF_SLOWPS: if (prot_q) slow_d = req.wdata[2:0];
            pcg_pkg::OFF_PROT:   prot_d = req.wdata[0];
            pcg_pkg::OFF_PLLRAT: pll_d = req.wdata[3:0];
            default:             ;
         endcase
      end
      if (req.rd) begin
         case (req.addr)
            pcg_pkg::OFF_GATE3:  rdata_d = {2'h0, gate_q, 8'h00};
            pcg_pkg::OFF_FASTPS: rdata_d = {13'h0000, fast_q};
            pcg_pkg::OFF_SLOWPS: rdata_d = {13'h0000, slow_q};
            pcg_pkg::OFF_PROT:   rdata_d = {15'h0000, prot_q};
            pcg_pkg::OFF_PLLRAT: rdata_d = {12'h000, pll_q};
            pcg_pkg::OFF_STATUS: rdata_d = {6'h00, fclk_q, sclk_q, 2'h0, gout_q};
            default:             rdata_d = 16'h0000;
         endcase
      end
   end

   // Divider next state; ratio changes only at safe boundaries, gate output copies control every cycle
   always_comb begin
      gout_d = gate_q;
      fact_d = fact_q;
      fcnt_d = fcnt_q;
      fclk_d = fclk_q;
      sact_d = sact_q;
      scnt_d = scnt_q;
      sclk_d = sclk_q;
      // Fast clock
      if (fact_q == 3'h0) begin
         fclk_d = 1'b1;
         fact_d = fast_q;
         fcnt_d = 4'h0;
         if (fast_q != 3'h0) fclk_d = 1'b0;
      end else if (fcnt_q == {1'b0, fact_q} - 4'h1) begin
         fcnt_d = 4'h0;
         fclk_d = ~fclk_q;
         if (fclk_q) fact_d = fast_q;
      end else begin
         fcnt_d = fcnt_q + 4'h1;
      end
      // Slow clock
      if (sact_q == 3'h0) begin
         sclk_d = 1'b1;
         sact_d = slow_q;
         scnt_d = 4'h0;
         if (slow_q != 3'h0) sclk_d = 1'b0;
      end else if (scnt_q == {1'b0, sact_q} - 4'h1) begin
         scnt_d = 4'h0;
         sclk_d = ~sclk_q;
         if (sclk_q) sact_d = slow_q;
      end else begin
         scnt_d = scnt_q + 4'h1;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         gate_q  <= pcg_pkg::GATE_RST;
         fast_q  <= pcg_pkg::FAST_RST;
         slow_q  <= pcg_pkg::SLOW_RST;
         prot_q  <= 1'b0;
         pll_q   <= pcg_pkg::PLL_RST;
         rdata_q <= 16'h0000;
         gout_q  <= pcg_pkg::GATE_RST;
         fact_q  <= pcg_pkg::FAST_RST;
         fcnt_q  <= 4'h0;
         fclk_q  <= 1'b0;
         sact_q  <= pcg_pkg::SLOW_RST;
         scnt_q  <= 4'h0;
         sclk_q  <= 1'b0;
      end else begin
         gate_q  <= gate_d;
         fast_q  <= fast_d;
         slow_q  <= slow_d;
         prot_q  <= prot_d;
         pll_q   <= pll_d;
         rdata_q <= rdata_d;
         gout_q  <= gout_d;
         fact_q  <= fact_d;
         fcnt_q  <= fcnt_d;
         fclk_q  <= fclk_d;
         sact_q  <= sact_d;
         scnt_q  <= scnt_d;
         sclk_q  <= sclk_d;
      end
   end

   assign rdata             = rdata_q;
   assign gates             = gout_q;
   assign fast_periph_clock = fclk_q;
   assign slow_periph_clock = sclk_q;
   assign pll_ratio         = pll_q;

   // Checks
   a_gate_follows: assert property (@(posedge mclk) disable iff (!nrst)
      gout_q == $past(gate_q)) else $error("gate output lags control");
   a_fast_prot: assert property (@(posedge mclk) disable iff (!nrst)
      (req.wr && req.addr == pcg_pkg::OFF_FASTPS && !prot_q) |=> $stable(fast_q))
      else $error("unprotected fast write taken");
   a_slow_prot: assert property (@(posedge mclk) disable iff (!nrst)
      (req.wr && req.addr == pcg_pkg::OFF_SLOWPS && !prot_q) |=> $stable(slow_q))
      else $error("unprotected slow write taken");
   a_fast_div2: assert property (@(posedge mclk) disable iff (!nrst)
      (fact_q == 3'h1 && fast_q == 3'h1 && $rose(fclk_q)) |=> !fclk_q ##1 fclk_q)
      else $error("fast divide by two wrong");
   a_slow_div4: assert property (@(posedge mclk) disable iff (!nrst)
      (sact_q == 3'h2 && slow_q == 3'h2 && $rose(sclk_q)) |=> sclk_q ##1 !sclk_q)
      else $error("slow divide by four wrong");
   a_fast_high: assert property (@(posedge mclk) disable iff (!nrst)
      (fact_q != 3'h0 && $rose(fclk_q)) |=> fclk_q || $past(fact_q) == 3'h1)
      else $error("fast clock runt pulse");
   a_read_rsvd: assert property (@(posedge mclk) disable iff (!nrst)
      (req.rd && req.addr == pcg_pkg::OFF_GATE3) |=> (rdata_q & ~pcg_pkg::GATE_MASK) == 16'h0)
      else $error("reserved gate bits not zero");
   a_pll_write: assert property (@(posedge mclk) disable iff (!nrst)
      (req.wr && req.addr == pcg_pkg::OFF_PLLRAT) |=> pll_q == $past(req.wdata[3:0]))
      else $error("ratio write lost");
   a_fast_read: assert property (@(posedge mclk) disable iff (!nrst)
      (req.rd && req.addr == pcg_pkg::OFF_FASTPS) |=> rdata_q == {13'h0000, $past(fast_q)})
      else $error("fast prescaler read wrong");

   // Register port checks
   a_gate_write: assert property (@(posedge mclk) disable iff (!nrst)
      (req.wr && req.addr == pcg_pkg::OFF_GATE3)
      |=> gate_q == $past(req.wdata[BITHI:pcg_pkg::BIT_TMR0])) else $error("gate write lost");

   a_gate_hold: assert property (@(posedge mclk) disable iff (!nrst)
      !(req.wr && req.addr == pcg_pkg::OFF_GATE3) |=> $stable(gate_q))
      else $error("gate changed without write");

   a_fast_take: assert property (@(posedge mclk) disable iff (!nrst)
      (req.wr && req.addr == pcg_pkg::OFF_FASTPS && prot_q) |=> fast_q == $past(req.wdata[2:0]))
      else $error("protected fast write lost");

   a_slow_take: assert property (@(posedge mclk) disable iff (!nrst)
      (req.wr && req.addr == pcg_pkg::OFF_SLOWPS && prot_q) |=> slow_q == $past(req.wdata[2:0]))
      else $error("protected slow write lost");

   a_prot_write: assert property (@(posedge mclk) disable iff (!nrst)
      (req.wr && req.addr == pcg_pkg::OFF_PROT) |=> prot_q == $past(req.wdata[0]))
      else $error("access enable write lost");

   a_pll_hold: assert property (@(posedge mclk) disable iff (!nrst)
      !(req.wr && req.addr == pcg_pkg::OFF_PLLRAT) |=> $stable(pll_q))
      else $error("ratio changed without write");

   a_rdata_idle: assert property (@(posedge mclk) disable iff (!nrst)
      !req.rd |=> rdata_q == 16'h0000) else $error("read data without read");

   a_gate_read: assert property (@(posedge mclk) disable iff (!nrst)
      (req.rd && req.addr == pcg_pkg::OFF_GATE3) |=> rdata_q == {2'h0, $past(gate_q), 8'h00})
      else $error("gate read wrong");

   a_slow_read: assert property (@(posedge mclk) disable iff (!nrst)
      (req.rd && req.addr == pcg_pkg::OFF_SLOWPS) |=> rdata_q == {13'h0000, $past(slow_q)})
      else $error("slow prescaler read wrong");

   a_prot_read: assert property (@(posedge mclk) disable iff (!nrst)
      (req.rd && req.addr == pcg_pkg::OFF_PROT) |=> rdata_q == {15'h0000, $past(prot_q)})
      else $error("access enable read wrong");

   a_pll_read: assert property (@(posedge mclk) disable iff (!nrst)
      (req.rd && req.addr == pcg_pkg::OFF_PLLRAT) |=> rdata_q == {12'h000, $past(pll_q)})
      else $error("ratio read wrong");

   a_status_read: assert property (@(posedge mclk) disable iff (!nrst)
      (req.rd && req.addr == pcg_pkg::OFF_STATUS)
      |=> rdata_q == {6'h00, $past(fclk_q), $past(sclk_q), 2'h0, $past(gout_q)})
      else $error("status read wrong");

   a_unmapped_read: assert property (@(posedge mclk) disable iff (!nrst)
      (req.rd && req.addr > pcg_pkg::OFF_STATUS) |=> rdata_q == 16'h0000)
      else $error("unmapped read not zero");

   // Divider checks
   a_fast_zero: assert property (@(posedge mclk) disable iff (!nrst)
      (fact_q == 3'h0 && fast_q == 3'h0) |=> fclk_q) else $error("fast full rate wrong");

   a_slow_zero: assert property (@(posedge mclk) disable iff (!nrst)
      (sact_q == 3'h0 && slow_q == 3'h0) |=> sclk_q) else $error("slow full rate wrong");

   a_slow_high: assert property (@(posedge mclk) disable iff (!nrst)
      (sact_q != 3'h0 && $rose(sclk_q)) |=> sclk_q || $past(sact_q) == 3'h1)
      else $error("slow clock runt pulse");

   a_fast_low: assert property (@(posedge mclk) disable iff (!nrst)
      (fact_q > 3'h1 && $fell(fclk_q)) |=> !fclk_q) else $error("fast clock short low");

   a_slow_low: assert property (@(posedge mclk) disable iff (!nrst)
      (sact_q > 3'h1 && $fell(sclk_q)) |=> !sclk_q) else $error("slow clock short low");

   a_fast_cnt_range: assert property (@(posedge mclk) disable iff (!nrst)
      (fact_q != 3'h0) |-> fcnt_q < {1'b0, fact_q}) else $error("fast count out of range");

   a_slow_cnt_range: assert property (@(posedge mclk) disable iff (!nrst)
      (sact_q != 3'h0) |-> scnt_q < {1'b0, sact_q}) else $error("slow count out of range");

   a_fast_adopt: assert property (@(posedge mclk) disable iff (!nrst)
      (fact_q != 3'h0 && $fell(fclk_q)) |-> fact_q == $past(fast_q))
      else $error("fast ratio not adopted");

   a_slow_adopt: assert property (@(posedge mclk) disable iff (!nrst)
      (sact_q != 3'h0 && $fell(sclk_q)) |-> sact_q == $past(slow_q))
      else $error("slow ratio not adopted");

   // High phase length per ratio
   a_fast_div4: assert property (@(posedge mclk) disable iff (!nrst)
      (fact_q == 3'h2 && $rose(fclk_q)) |=> fclk_q ##1 !fclk_q)
      else $error("fast divide by four wrong");

   a_fast_div6: assert property (@(posedge mclk) disable iff (!nrst)
      (fact_q == 3'h3 && $rose(fclk_q)) |=> fclk_q[*2] ##1 !fclk_q)
      else $error("fast divide by six wrong");

   a_fast_div8: assert property (@(posedge mclk) disable iff (!nrst)
      (fact_q == 3'h4 && $rose(fclk_q)) |=> fclk_q[*3] ##1 !fclk_q)
      else $error("fast divide by eight wrong");

   a_fast_div10: assert property (@(posedge mclk) disable iff (!nrst)
      (fact_q == 3'h5 && $rose(fclk_q)) |=> fclk_q[*4] ##1 !fclk_q)
      else $error("fast divide by ten wrong");

   a_fast_div12: assert property (@(posedge mclk) disable iff (!nrst)
      (fact_q == 3'h6 && $rose(fclk_q)) |=> fclk_q[*5] ##1 !fclk_q)
      else $error("fast divide by twelve wrong");

   a_fast_div14: assert property (@(posedge mclk) disable iff (!nrst)
      (fact_q == 3'h7 && $rose(fclk_q)) |=> fclk_q[*6] ##1 !fclk_q)
      else $error("fast divide by fourteen wrong");

   a_slow_div2: assert property (@(posedge mclk) disable iff (!nrst)
      (sact_q == 3'h1 && $rose(sclk_q)) |=> !sclk_q)
      else $error("slow divide by two wrong");

   a_slow_div6: assert property (@(posedge mclk) disable iff (!nrst)
      (sact_q == 3'h3 && $rose(sclk_q)) |=> sclk_q[*2] ##1 !sclk_q)
      else $error("slow divide by six wrong");

   a_slow_div8: assert property (@(posedge mclk) disable iff (!nrst)
      (sact_q == 3'h4 && $rose(sclk_q)) |=> sclk_q[*3] ##1 !sclk_q)
      else $error("slow divide by eight wrong");

   a_slow_div10: assert property (@(posedge mclk) disable iff (!nrst)
      (sact_q == 3'h5 && $rose(sclk_q)) |=> sclk_q[*4] ##1 !sclk_q)
      else $error("slow divide by ten wrong");

   a_slow_div12: assert property (@(posedge mclk) disable iff (!nrst)
      (sact_q == 3'h6 && $rose(sclk_q)) |=> sclk_q[*5] ##1 !sclk_q)
      else $error("slow divide by twelve wrong");

   a_slow_div14: assert property (@(posedge mclk) disable iff (!nrst)
      (sact_q == 3'h7 && $rose(sclk_q)) |=> sclk_q[*6] ##1 !sclk_q)
      else $error("slow divide by fourteen wrong");
endmodule
`default_nettype wire

/* File: sim/pcg_periph_model.sv */
// Peripheral that receives a divided clock and measures its period
// Assumes pclk is produced from mclk and changes only after mclk rises
`timescale 1ns/10ps
`default_nettype none
module pcg_periph_model (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       nrst,
   // Divided clock
   input  wire logic       pclk,
   output logic      [4:0] period
);
   logic       prev_q;
   logic [4:0] cnt_q;
   // Mclk cycles between rising edges
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         prev_q <= 1'b0;
         cnt_q  <= 5'h0;
         period <= 5'h0;
      end else begin
         prev_q <= pclk;
         cnt_q  <= (pclk && !prev_q) ? 5'h1 : cnt_q + 5'h1;
         if (pclk && !prev_q) begin
            period <= cnt_q;
         end
      end
   end
endmodule
`default_nettype wire

/* File: sim/pcg_top_bench.sv */
// Testbench for the clock gate and prescale unit
// Assumes registers at the package offsets and unprotected PLL ratio
`timescale 1ns/10ps
`default_nettype none
module pcg_top_bench;
   logic                mclk, nrst;
   pcg_pkg::pcg_req_t   req;
   logic [15:0]         rdata;
   pcg_pkg::pcg_gates_t gates;
   logic                fclk, sclk;
   logic [3:0]          pll;
   logic [4:0]          fper, sper;
   logic [5:0]          gv;
   int                  mismatches, checked;
   assign gv = {gates.pin_input_clock_on, gates.ext_memory_if_clock_on, gates.dma_clock_on,
                gates.timer_two_clock_on, gates.timer_one_clock_on, gates.timer_zero_clock_on};
   pcg_top i_dut (.mclk(mclk), .nrst(nrst), .req(req), .rdata(rdata), .gates(gates),
      .fast_periph_clock(fclk), .slow_periph_clock(sclk), .pll_ratio(pll));
   pcg_periph_model i_fast (.mclk(mclk), .nrst(nrst), .pclk(fclk), .period(fper));
   pcg_periph_model i_slow (.mclk(mclk), .nrst(nrst), .pclk(sclk), .period(sper));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk) req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge mclk) req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
      @(posedge mclk) req.rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge mclk);
      mismatches++;
      give_verdict();
   end
   initial begin
      req = '0;
      nrst = 1'b0;
      mismatches = 0;
      checked = 0;
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      rd(pcg_pkg::OFF_GATE3, 16'h2700);
      chk({10'h0, gv}, 16'h0027);
      rd(pcg_pkg::OFF_FASTPS, 16'h0001);
      rd(pcg_pkg::OFF_SLOWPS, 16'h0002);
      repeat (30) @(posedge mclk);
      chk({11'h0, fper}, 16'h0002);
      chk({11'h0, sper}, 16'h0004);
      wr(pcg_pkg::OFF_FASTPS, 16'h0003);
      rd(pcg_pkg::OFF_FASTPS, 16'h0001);
      wr(pcg_pkg::OFF_PROT, 16'h0001);
      wr(pcg_pkg::OFF_FASTPS, 16'hfff3);
      rd(pcg_pkg::OFF_FASTPS, 16'h0003);
      wr(pcg_pkg::OFF_SLOWPS, 16'h0007);
      repeat (60) @(posedge mclk);
      chk({11'h0, fper}, 16'h0006);
      chk({11'h0, sper}, 16'h000e);
      wr(pcg_pkg::OFF_FASTPS, 16'h0000);
      repeat (30) @(posedge mclk);
      chk({15'h0, fclk}, 16'h0001);
      wr(pcg_pkg::OFF_PROT, 16'h0000);
      wr(pcg_pkg::OFF_SLOWPS, 16'h0001);
      rd(pcg_pkg::OFF_SLOWPS, 16'h0007);
      for (int i = 0; i < 6; i++) begin
         wr(pcg_pkg::OFF_GATE3, (16'h0100 << i) | 16'hc0ff);
         repeat (2) @(posedge mclk);
         #1 chk({10'h0, gv}, 16'h0001 << i);
         rd(pcg_pkg::OFF_GATE3, 16'h0100 << i);
      end
      wr(pcg_pkg::OFF_PLLRAT, 16'hffa5);
      rd(pcg_pkg::OFF_PLLRAT, 16'h0005);
      chk({12'h0, pll}, 16'h0005);
      wr(4'hf, 16'hffff);
      rd(4'hf, 16'h0000);
      give_verdict();
   end
endmodule
`default_nettype wire
